// File: verilog/csdec_pkg.sv
// Purpose: shared constants and types for the chip-select address decoder
// Assumes: 24-bit processor address, APB register access with 32-bit data
// Notes:   all ranges are inclusive, low 16 bits inside bank zero
package csdec_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0]  CTRL_OFS   = 8'h00;
	localparam logic [7:0]  STAT_OFS   = 8'h04;

	// control field positions
	localparam int ROM_EN_BIT   = 0;
	localparam int LRAM_EN_BIT  = 1;
	localparam int XROM_EN_BIT  = 2;
	localparam int RAM_SEL_BIT  = 3;
	localparam int XBUS_EN_BIT  = 4;
	localparam int FLASH_A_BIT  = 5;
	localparam int FLASH_B_BIT  = 6;
	localparam int CTRL_W       = 7;
	localparam logic [6:0] CTRL_RST = 7'h07;

	// ----------------------------------------
	// address windows
	// ----------------------------------------
	localparam logic [7:0]  BANK_ZERO     = 8'h00;
	localparam logic [7:0]  GEN_BANK_HI   = 8'h3F;
	localparam logic [7:0]  MID_BANK_LO   = 8'h40;
	localparam logic [7:0]  MID_BANK_HI   = 8'hBF;
	localparam logic [7:0]  HIGH_BANK_LO  = 8'hC0;
	localparam logic [15:0] REGPG_LO      = 16'hDF00;
	localparam logic [15:0] REGPG_HI      = 16'hDFFF;
	localparam logic [15:0] P0_HI         = 16'hDF1F;
	localparam logic [15:0] IOREG0_HI     = 16'hDF07;
	localparam logic [15:0] IOREG1_LO     = 16'hDF20;
	localparam logic [15:0] IOREG1_HI     = 16'hDF27;
	localparam logic [15:0] CTLREG_LO     = 16'hDF40;
	localparam logic [15:0] OCRAM_HI      = 16'hDFBF;
	localparam logic [15:0] P1_LO         = 16'hDFC0;
	localparam logic [15:0] IROM_LO       = 16'hE000;
	localparam logic [15:0] IROM_HI       = 16'hFEFF;
	localparam logic [15:0] VEC_LO        = 16'hFF00;
	localparam logic [15:0] TOP_HI        = 16'hFFFF;
	localparam logic [15:0] XROM_LO       = 16'h8000;
	localparam logic [15:0] XROM_HI       = 16'hDEFF;
	localparam logic [15:0] LRAM_LO_INT   = 16'h0200;
	localparam logic [15:0] LRAM_LO_EXT   = 16'h0000;
	localparam logic [15:0] LRAM_HI       = 16'h7FFF;
	localparam logic [15:0] IRAM_HI       = 16'h01FF;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef struct packed {
		logic flash_b;
		logic flash_a;
		logic xbus_en;
		logic ram_sel;
		logic xrom_en;
		logic lram_en;
		logic rom_en;
	} csdec_cfg_t;

	// active-high strobe image, bit n is strobe n
	typedef struct packed {
		logic high_mem;
		logic mid_mem;
		logic gen_mem;
		logic ext_rom;
		logic low_ram;
		logic onchip;
		logic periph1;
		logic periph0;
	} csdec_sel_t;

endpackage

// File: verilog/csdec_top.sv
// Purpose: turns the processor address into active-low chip-select strobes
// Assumes: PROC_ADDR comes from logic on CORE_CLK, so it is not synchronised
// Notes:   strobes are registered, one cycle behind the address
//
// Notes on behaviour
// - with on-chip ROM on, E000-FFFF of bank zero never raises the ROM strobe
// - register page DF00-DFFF never raises the ROM or general strobe
// - general strobe drops wherever on-chip ROM, low RAM or ROM strobe claims
// - peripheral strobe ranges never raise on-chip, ROM or general strobes
// - internal RAM selected: low RAM strobe covers 0200-7FFF of bank zero
// - external RAM selected: low RAM strobe covers 0000-7FFF of bank zero
// - external bus off: DF00-DF07 are internal registers, peripheral zero idle
// - external bus on: peripheral zero covers DF00-DF1F
// - two port outputs drive the upper flash address lines for overlays
// - on-chip strobe covers vectors, ROM, RAM and register blocks of bank zero
`timescale 1ns/1ps

module csdec_top (
	// clock and reset
	input  wire logic        CORE_CLK,
	input  wire logic        RST_N,
	// processor address
	input  wire logic [23:0] PROC_ADDR,
	// apb slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// chip selects
	output logic             PERIPH_STROBE_ZERO_N,
	output logic             PERIPH_STROBE_ONE_N,
	output logic             ONCHIP_REGION_STROBE_N,
	output logic             LOW_RAM_STROBE_N,
	output logic             EXT_ROM_STROBE_N,
	output logic             GENERAL_MEM_STROBE_N,
	output logic             USER_MEM_STROBE_MID_N,
	output logic             USER_MEM_STROBE_HIGH_N,
	// flash overlay port lines
	output logic             FLASH_UPPER_ADDR_A,
	output logic             FLASH_UPPER_ADDR_B
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic in_win(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
		in_win = (a >= lo) && (a <= hi);
	endfunction

	csdec_pkg::csdec_cfg_t cfg;
	csdec_pkg::csdec_sel_t sel;
	csdec_pkg::csdec_sel_t next_sel;

	wire logic [7:0]  bank = PROC_ADDR[23:16];
	wire logic [15:0] ofs  = PROC_ADDR[15:0];
	wire logic        b0   = (bank == csdec_pkg::BANK_ZERO);

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire logic regpg   = b0 && in_win(ofs, csdec_pkg::REGPG_LO, csdec_pkg::REGPG_HI);
	wire logic p1_hit  = b0 && in_win(ofs, csdec_pkg::P1_LO, csdec_pkg::REGPG_HI);
	// peripheral zero only exists with the external bus on
	wire logic p0_hit  = b0 && cfg.xbus_en && in_win(ofs, csdec_pkg::REGPG_LO, csdec_pkg::P0_HI);
	wire logic io0_hit = b0 && !cfg.xbus_en && in_win(ofs, csdec_pkg::REGPG_LO, csdec_pkg::IOREG0_HI);
	wire logic iram    = b0 && !cfg.ram_sel && in_win(ofs, 16'h0000, csdec_pkg::IRAM_HI);
	wire logic irom    = b0 && cfg.rom_en && in_win(ofs, csdec_pkg::IROM_LO, csdec_pkg::IROM_HI);
	// on-chip region, minus anything a peripheral strobe owns
	wire logic oc_hit  = (b0 && in_win(ofs, csdec_pkg::VEC_LO, csdec_pkg::TOP_HI))
	                   || irom || iram || io0_hit
	                   || (b0 && in_win(ofs, csdec_pkg::IOREG1_LO, csdec_pkg::IOREG1_HI))
	                   || (b0 && in_win(ofs, csdec_pkg::CTLREG_LO, csdec_pkg::OCRAM_HI));
	wire logic oc_sel  = oc_hit && !p0_hit && !p1_hit;
	wire logic [15:0] lram_lo = cfg.ram_sel ? csdec_pkg::LRAM_LO_EXT : csdec_pkg::LRAM_LO_INT;
	wire logic lr_sel  = b0 && cfg.lram_en && in_win(ofs, lram_lo, csdec_pkg::LRAM_HI);
	// top of bank zero belongs to the internal ROM while it is on; vectors stay on-chip
	wire logic xr_top  = !cfg.rom_en && in_win(ofs, csdec_pkg::IROM_LO, csdec_pkg::IROM_HI);
	wire logic xr_sel  = b0 && cfg.xrom_en && !regpg && !p0_hit && !p1_hit
	                   && (in_win(ofs, csdec_pkg::XROM_LO, csdec_pkg::XROM_HI) || xr_top);
	wire logic gen_rng = (bank <= csdec_pkg::GEN_BANK_HI);
	// general memory takes only what nobody else claimed
	wire logic gm_sel  = gen_rng && !regpg && !p0_hit && !p1_hit && !irom && !oc_sel
	                   && !lr_sel && !xr_sel;
	wire logic mid_sel = (bank >= csdec_pkg::MID_BANK_LO) && (bank <= csdec_pkg::MID_BANK_HI);
	wire logic hi_sel  = (bank >= csdec_pkg::HIGH_BANK_LO);

	always_comb begin
		next_sel          = '0;
		next_sel.periph0  = p0_hit;
		next_sel.periph1  = p1_hit;
		next_sel.onchip   = oc_sel;
		next_sel.low_ram  = lr_sel;
		next_sel.ext_rom  = xr_sel;
		next_sel.gen_mem  = gm_sel;
		next_sel.mid_mem  = mid_sel;
		next_sel.high_mem = hi_sel;
	end

	// strobes released under reset, no glitches from comb decode
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sel <= '0;
		end else begin
			sel <= next_sel;
		end
	end

	// pins leave straight from flip-flops, so a decode race never reaches a device
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			PERIPH_STROBE_ZERO_N   <= 1'b1;
			PERIPH_STROBE_ONE_N    <= 1'b1;
			ONCHIP_REGION_STROBE_N <= 1'b1;
			LOW_RAM_STROBE_N       <= 1'b1;
			EXT_ROM_STROBE_N       <= 1'b1;
			GENERAL_MEM_STROBE_N   <= 1'b1;
			USER_MEM_STROBE_MID_N  <= 1'b1;
			USER_MEM_STROBE_HIGH_N <= 1'b1;
		end else begin
			PERIPH_STROBE_ZERO_N   <= !next_sel.periph0;
			PERIPH_STROBE_ONE_N    <= !next_sel.periph1;
			ONCHIP_REGION_STROBE_N <= !next_sel.onchip;
			LOW_RAM_STROBE_N       <= !next_sel.low_ram;
			EXT_ROM_STROBE_N       <= !next_sel.ext_rom;
			GENERAL_MEM_STROBE_N   <= !next_sel.gen_mem;
			USER_MEM_STROBE_MID_N  <= !next_sel.mid_mem;
			USER_MEM_STROBE_HIGH_N <= !next_sel.high_mem;
		end
	end

	assign FLASH_UPPER_ADDR_A     = cfg.flash_a;
	assign FLASH_UPPER_ADDR_B     = cfg.flash_b;

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	wire logic setup    = PSEL && !PENABLE;
	wire logic hit_ctrl = (PADDR == csdec_pkg::CTRL_OFS);
	wire logic hit_stat = (PADDR == csdec_pkg::STAT_OFS);
	wire logic mapped   = hit_ctrl || hit_stat;
	wire logic do_wr    = PSEL && PENABLE && PREADY && PWRITE && hit_ctrl;
	logic [31:0] rd_mux;

	always_comb begin
		if (hit_ctrl) begin
			rd_mux = {25'h0000000, cfg};
		end else if (hit_stat) begin
			rd_mux = {24'h000000, sel};
		end else begin
			rd_mux = 32'h00000000;
		end
	end

	// one wait-free access phase: ready rises in the cycle after setup
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h00000000;
		end else begin
			PREADY  <= setup;
			PSLVERR <= setup && !mapped;
			PRDATA  <= (setup && !PWRITE) ? rd_mux : 32'h00000000;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			cfg <= csdec_pkg::CTRL_RST;
		end else if (do_wr) begin
			cfg <= PWDATA[csdec_pkg::CTRL_W-1:0];
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);

	a_single_strobe: assert property ($past(RST_N) |-> $onehot0(sel))
		else $error("more than one strobe active");
	a_rom_top_excl: assert property (cfg.rom_en && b0 && ofs >= csdec_pkg::IROM_LO
		|=> EXT_ROM_STROBE_N)
		else $error("rom strobe in internal rom area");
	a_regpage_quiet: assert property (regpg |=> EXT_ROM_STROBE_N && GENERAL_MEM_STROBE_N)
		else $error("rom or general strobe on register page");
	a_general_yield: assert property (!LOW_RAM_STROBE_N || !EXT_ROM_STROBE_N
		|-> GENERAL_MEM_STROBE_N)
		else $error("general strobe overlaps claimed region");
	a_periph_excl: assert property (p0_hit || p1_hit
		|=> ONCHIP_REGION_STROBE_N && EXT_ROM_STROBE_N && GENERAL_MEM_STROBE_N)
		else $error("peripheral range leaked to other strobe");
	a_lowram_int: assert property (cfg.lram_en && !cfg.ram_sel && b0 && ofs <= csdec_pkg::LRAM_HI
		|=> LOW_RAM_STROBE_N == ($past(ofs) < csdec_pkg::LRAM_LO_INT))
		else $error("low ram strobe wrong with internal ram");
	a_lowram_ext: assert property (cfg.lram_en && cfg.ram_sel && b0 && ofs <= csdec_pkg::LRAM_HI
		|=> !LOW_RAM_STROBE_N)
		else $error("low ram strobe missing with external ram");
	a_p0_off: assert property (!cfg.xbus_en |=> PERIPH_STROBE_ZERO_N)
		else $error("peripheral zero active with bus off");
	a_p0_on: assert property (cfg.xbus_en && b0 && ofs >= csdec_pkg::REGPG_LO && ofs <= csdec_pkg::P0_HI
		|=> !PERIPH_STROBE_ZERO_N)
		else $error("peripheral zero missing with bus on");
	a_flash_lines: assert property (do_wr |=> FLASH_UPPER_ADDR_A == $past(PWDATA[csdec_pkg::FLASH_A_BIT])
		&& FLASH_UPPER_ADDR_B == $past(PWDATA[csdec_pkg::FLASH_B_BIT]))
		else $error("flash overlay lines not updated");
	a_vector_onchip: assert property (b0 && ofs >= csdec_pkg::VEC_LO |=> !ONCHIP_REGION_STROBE_N)
		else $error("vector area missing on-chip strobe");
	a_apb_ready: assert property (setup |=> PREADY ##1 !PREADY)
		else $error("apb ready not a single access cycle");

	// ----------------------------------------
	// range checks, written from the map rather than the decode wires
	// ----------------------------------------
	a_p1_on: assert property (b0 && in_win(ofs, csdec_pkg::P1_LO, csdec_pkg::REGPG_HI)
		|=> !PERIPH_STROBE_ONE_N)
		else $error("peripheral one missing in its range");
	a_p1_off: assert property (!(b0 && in_win(ofs, csdec_pkg::P1_LO, csdec_pkg::REGPG_HI))
		|=> PERIPH_STROBE_ONE_N)
		else $error("peripheral one outside its range");
	a_p1_excl: assert property (b0 && in_win(ofs, csdec_pkg::P1_LO, csdec_pkg::REGPG_HI)
		|=> ONCHIP_REGION_STROBE_N && EXT_ROM_STROBE_N && GENERAL_MEM_STROBE_N)
		else $error("peripheral one range leaked");
	a_p0_outside: assert property (!(b0 && in_win(ofs, csdec_pkg::REGPG_LO, csdec_pkg::P0_HI))
		|=> PERIPH_STROBE_ZERO_N)
		else $error("peripheral zero outside its range");
	a_io_regs_onchip: assert property (!cfg.xbus_en && b0 && in_win(ofs, csdec_pkg::REGPG_LO, csdec_pkg::IOREG0_HI)
		|=> !ONCHIP_REGION_STROBE_N)
		else $error("internal registers missing on-chip strobe");
	a_unclaimed_gap: assert property (!cfg.xbus_en && b0 && ofs > csdec_pkg::IOREG0_HI && ofs <= csdec_pkg::P0_HI
		|=> ONCHIP_REGION_STROBE_N && PERIPH_STROBE_ZERO_N && GENERAL_MEM_STROBE_N)
		else $error("unclaimed register gap raised a strobe");
	a_iram_onchip: assert property (!cfg.ram_sel && b0 && in_win(ofs, 16'h0000, csdec_pkg::IRAM_HI)
		|=> !ONCHIP_REGION_STROBE_N)
		else $error("internal ram missing on-chip strobe");
	a_irom_onchip: assert property (cfg.rom_en && b0 && in_win(ofs, csdec_pkg::IROM_LO, csdec_pkg::IROM_HI)
		|=> !ONCHIP_REGION_STROBE_N)
		else $error("internal rom missing on-chip strobe");
	a_ctl_onchip: assert property (b0 && in_win(ofs, csdec_pkg::CTLREG_LO, csdec_pkg::OCRAM_HI)
		|=> !ONCHIP_REGION_STROBE_N)
		else $error("control blocks missing on-chip strobe");
	a_onchip_bank: assert property (!b0 |=> ONCHIP_REGION_STROBE_N)
		else $error("on-chip strobe outside bank zero");
	a_lowram_off: assert property (!cfg.lram_en |=> LOW_RAM_STROBE_N)
		else $error("low ram strobe while disabled");
	a_lowram_bank: assert property (!b0 || ofs > csdec_pkg::LRAM_HI |=> LOW_RAM_STROBE_N)
		else $error("low ram strobe above its range");
	a_xrom_low: assert property (cfg.xrom_en && b0 && in_win(ofs, csdec_pkg::XROM_LO, csdec_pkg::XROM_HI)
		|=> !EXT_ROM_STROBE_N)
		else $error("rom strobe missing in its range");
	a_xrom_off: assert property (!cfg.xrom_en |=> EXT_ROM_STROBE_N)
		else $error("rom strobe while disabled");
	a_xrom_vectors: assert property (b0 && ofs >= csdec_pkg::VEC_LO |=> EXT_ROM_STROBE_N)
		else $error("rom strobe on vector area");
	a_general_rom: assert property (!ONCHIP_REGION_STROBE_N |-> GENERAL_MEM_STROBE_N)
		else $error("general strobe over on-chip region");
	a_general_bank: assert property (bank > csdec_pkg::GEN_BANK_HI |=> GENERAL_MEM_STROBE_N)
		else $error("general strobe above its banks");
	a_mid_banks: assert property (bank >= csdec_pkg::MID_BANK_LO && bank <= csdec_pkg::MID_BANK_HI
		|=> !USER_MEM_STROBE_MID_N && USER_MEM_STROBE_HIGH_N && GENERAL_MEM_STROBE_N)
		else $error("mid bank strobes wrong");
	a_high_banks: assert property (bank >= csdec_pkg::HIGH_BANK_LO
		|=> !USER_MEM_STROBE_HIGH_N && USER_MEM_STROBE_MID_N && GENERAL_MEM_STROBE_N)
		else $error("high bank strobes wrong");

	// ----------------------------------------
	// register bus checks
	// ----------------------------------------
	a_apb_error: assert property (PSEL && !PENABLE && PADDR != csdec_pkg::CTRL_OFS && PADDR != csdec_pkg::STAT_OFS
		|=> PREADY && PSLVERR)
		else $error("unmapped access without error");
	a_ready_origin: assert property (PREADY |-> $past(PSEL && !PENABLE))
		else $error("ready without setup");
	a_rd_idle: assert property (!PREADY |-> PRDATA == 32'h00000000)
		else $error("read data outside access cycle");
	a_err_rdzero: assert property (PSLVERR |-> PRDATA == 32'h00000000)
		else $error("read data on error");
	a_ctrl_hold: assert property (!(PSEL && PENABLE && PREADY && PWRITE && PADDR == csdec_pkg::CTRL_OFS)
		|=> $stable(cfg))
		else $error("control changed without write");

	c_ext_ram: cover property (cfg.ram_sel && !LOW_RAM_STROBE_N);
	c_p0_bus: cover property (!PERIPH_STROBE_ZERO_N);
	c_gen_mem: cover property (!GENERAL_MEM_STROBE_N ##1 !USER_MEM_STROBE_HIGH_N);
	c_unmapped: cover property (PREADY && PSLVERR);

endmodule // csdec_top

// File: tb/csdec_ext_mem.sv
// Purpose: far-side devices that watch the chip-select strobes
// Assumes: every strobe is active low, one device per strobe
// Notes:   raises fight when two devices would drive the data bus at once
`timescale 1ns/1ps

module csdec_ext_mem (
	// strobes, bit n is strobe n
	input  wire logic [7:0] strobe_n,
	// bus fight seen
	output logic            fight
);
	// ----------------------------------------
	// selection count
	// ----------------------------------------
	// a double select would corrupt reads, so the devices report it
	assign fight = ($countones(~strobe_n) > 1);
endmodule // csdec_ext_mem

// File: tb/chip_select_address_decoder_tb.sv
// Purpose: self-checking bench for the chip-select decoder
// Assumes: strobes follow the address one edge later, apb answers without wait
// Notes:   every control value is walked, with corner and random addresses
`timescale 1ns/1ps

module chip_select_address_decoder_tb;
	logic              clk = 1'b0;
	logic              rst_n = 1'b0;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [23:0]       addr = '0;
	logic [7:0]        paddr = '0;
	logic [31:0]       pwdata = '0;
	logic [31:0]       prdata;
	logic [31:0]       rd;
	logic [31:0]       r;
	logic              pready;
	logic              pslverr;
	logic              err;
	logic              fa;
	logic              fb;
	logic              fight;
	logic [7:0]        stb_n;
	int                miscompares = 0;
	int                cmp_count = 0;
	csdec_pkg::csdec_cfg_t cfg;
	logic [23:0]       corners [21] = '{24'h00E000, 24'h00FEFF, 24'h00FF00, 24'h00DF00, 24'h00DF07,
		24'h00DF08, 24'h00DF1F, 24'h00DF20, 24'h00DFC0, 24'h00DFFF, 24'h000000, 24'h0001FF,
		24'h000200, 24'h007FFF, 24'h008000, 24'h00DEFF, 24'h010000, 24'h3FFFFF, 24'h400000,
		24'hBFFFFF, 24'hC00000};

	csdec_top i_csdec_top (.CORE_CLK(clk), .RST_N(rst_n), .PROC_ADDR(addr), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .PERIPH_STROBE_ZERO_N(stb_n[0]),
		.PERIPH_STROBE_ONE_N(stb_n[1]), .ONCHIP_REGION_STROBE_N(stb_n[2]), .LOW_RAM_STROBE_N(stb_n[3]),
		.EXT_ROM_STROBE_N(stb_n[4]), .GENERAL_MEM_STROBE_N(stb_n[5]), .USER_MEM_STROBE_MID_N(stb_n[6]),
		.USER_MEM_STROBE_HIGH_N(stb_n[7]), .FLASH_UPPER_ADDR_A(fa), .FLASH_UPPER_ADDR_B(fb));
	csdec_ext_mem i_csdec_ext_mem (.strobe_n(stb_n), .fight(fight));

	initial begin
		forever #50 clk = ~clk;
	end

	// ----------------------------------------
	// expected decode
	// ----------------------------------------
	function automatic logic rng(input logic [15:0] l, input logic [15:0] lo, input logic [15:0] hi);
		return l >= lo && l <= hi;
	endfunction

	function automatic csdec_pkg::csdec_sel_t ref_sel(input logic [23:0] a, input csdec_pkg::csdec_cfg_t c);
		csdec_pkg::csdec_sel_t s;
		logic [15:0] l;
		logic b0;
		l = a[15:0];
		b0 = (a[23:16] == 8'h00);
		s.onchip = b0 && (rng(l, 16'hFF00, 16'hFFFF) || (c.rom_en && rng(l, 16'hE000, 16'hFEFF))
			|| (!c.ram_sel && rng(l, 16'h0000, 16'h01FF)) || (!c.xbus_en && rng(l, 16'hDF00, 16'hDF07))
			|| rng(l, 16'hDF20, 16'hDF27) || rng(l, 16'hDF40, 16'hDFBF));
		s.periph1 = b0 && rng(l, 16'hDFC0, 16'hDFFF);
		s.periph0 = b0 && c.xbus_en && rng(l, 16'hDF00, 16'hDF1F);
		s.low_ram = b0 && c.lram_en && rng(l, c.ram_sel ? 16'h0000 : 16'h0200, 16'h7FFF);
		s.ext_rom = b0 && c.xrom_en && (rng(l, 16'h8000, 16'hDEFF) || (!c.rom_en && rng(l, 16'hE000, 16'hFEFF)));
		s.gen_mem = a[23:22] == 2'b00 && !(b0 && rng(l, 16'hDF00, 16'hDFFF))
			&& !(s.onchip || s.low_ram || s.ext_rom);
		s.mid_mem = a[23:22] == 2'b01 || a[23:22] == 2'b10;
		s.high_mem = a[23:22] == 2'b11;
		return s;
	endfunction

	// ----------------------------------------
	// compares and bus cycles
	// ----------------------------------------
	task automatic summarize();
		$display("comparisons %0d, miscompares %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk8(input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	task automatic chk32(input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			miscompares++;
			summarize();
		end
	endtask

	// one edge for the decoder to take the address, then look
	task automatic chk_addr(input logic [23:0] a);
		@(posedge clk);
		addr <= a;
		@(posedge clk);
		#1;
		chk8(~ref_sel(a, cfg), stb_n);
		chk32(32'h0, {31'h0, fight});
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'h7FBC));
		repeat (2) @(posedge clk);
		chk8(8'hFF, stb_n);
		chk32(32'h0, {30'h0, fb, fa});
		rst_n <= 1'b1;
		apb(1'b0, 8'h00, 32'h0);
		chk32(32'h07, rd);
		apb(1'b0, 8'h08, 32'h0);
		chk32(32'h1, {31'h0, err});
		chk32(32'h0, rd);
		for (int i = 0; i < 128; i++) begin
			cfg = 7'(i);
			apb(1'b1, 8'h00, 32'(i));
			// status is read-only, so this write must leave control alone
			apb(1'b1, 8'h04, $urandom);
			apb(1'b0, 8'h00, 32'h0);
			chk32(32'(i), rd);
			chk32(32'(i[6:5]), {30'h0, fb, fa});
			foreach (corners[k])
				chk_addr(corners[k]);
			repeat (4) begin
				r = $urandom;
				chk_addr({r[31] ? r[23:16] : 8'h00, r[15:0]});
			end
			apb(1'b0, 8'h04, 32'h0);
			chk32({24'h0, ref_sel(addr, cfg)}, rd);
		end
		summarize();
	end
endmodule // chip_select_address_decoder_tb
